// ---- include/bsc_pkg.sv ----
// What this block does
// - Latch update flag on live update rising
// - Latch error flag on each bit error while in sync
// - Latch count flag on nonzero bit rising
// - Latch sync flag on any sync change
// - Update flag plus enable requests interrupt
// - Error flag needs enable and port gate
// - Count flag needs enable and port gate
// - Sync flag needs enable and port gate
// - Twenty-four bit error counter
// - Error counter saturates at all ones
// - Error counter holds while out of sync
// - Error count split low word, high byte
// - Thirty-two bit received bit counter
// - Bit counter saturates at all ones
// - Bit counter holds while out of sync
// - Bit count split low then high word
// - Snapshot request copies counts to registers
// - Update live high when done, low on release
// - Nonzero live set by count, cleared on update
// - Sync lost live follows checker sync state
package bsc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS       = 8'h6C;
    localparam logic [7:0] OFS_LATCHED      = 8'h6E;
    localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h70;
    localparam logic [7:0] OFS_ERR_LOW      = 8'h74;
    localparam logic [7:0] OFS_ERR_HIGH     = 8'h76;
    localparam logic [7:0] OFS_BIT_LOW      = 8'h78;
    localparam logic [7:0] OFS_BIT_HIGH     = 8'h7A;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_SYNC   = 0;
    localparam int POS_COUNT  = 1;
    localparam int POS_ERROR  = 2;
    localparam int POS_UPDATE = 3;
    // ------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------
    localparam logic [15:0] RST_REG16   = 16'h0000;
    localparam logic [3:0]  RST_FLAGS   = 4'h0;
    localparam int          ERR_WIDTH   = 24;
    localparam int          BIT_WIDTH   = 32;
endpackage

// ---- rtl/bsc_bert_status.sv ----
`timescale 1ns/1ps
module bsc_bert_status (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        rx_bit_valid_i,
    input  wire logic        rx_bit_error_i,
    input  wire logic        sync_lost_live_i,
    input  wire logic        counter_snapshot_request_i,
    input  wire logic        port_status_irq_gate_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             irq_o,
    output logic             update_done_live_o
);
    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    logic [bsc_pkg::ERR_WIDTH-1:0] err_acc;
    logic [bsc_pkg::BIT_WIDTH-1:0] bit_acc;
    logic                          snap_req_reg;
    logic                          snap_pulse;
    logic                          err_event;
    logic                          counted_err;

    assign snap_pulse  = counter_snapshot_request_i && !snap_req_reg;
    // A bit in error, and the same bit once the checker is in sync
    assign err_event   = rx_bit_valid_i && rx_bit_error_i;
    assign counted_err = err_event && !sync_lost_live_i;

    bsc_sat_counter #(.WIDTH(bsc_pkg::ERR_WIDTH)) u_err_cnt (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .inc_i     (err_event),
        .hold_i    (sync_lost_live_i),
        .restart_i (snap_pulse),
        .count_o   (err_acc)
    );

    bsc_sat_counter #(.WIDTH(bsc_pkg::BIT_WIDTH)) u_bit_cnt (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .inc_i     (rx_bit_valid_i),
        .hold_i    (sync_lost_live_i),
        .restart_i (snap_pulse),
        .count_o   (bit_acc)
    );

    // ------------------------------------------------------------
    // Snapshot registers and live status
    // ------------------------------------------------------------
    logic [bsc_pkg::ERR_WIDTH-1:0] error_tally_reg;
    logic [bsc_pkg::BIT_WIDTH-1:0] received_bit_tally_reg;
    logic                          update_live_reg;
    logic                          nonzero_live_reg;
    logic                          sync_prev_reg;
    logic                          update_prev_reg;
    logic                          nonzero_prev_reg;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            error_tally_reg        <= '0;
            received_bit_tally_reg <= '0;
        end else if (snap_pulse) begin
            error_tally_reg        <= err_acc;
            received_bit_tally_reg <= bit_acc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            snap_req_reg    <= 1'b0;
            update_live_reg <= 1'b0;
        end else begin
            snap_req_reg <= counter_snapshot_request_i;
            if (!counter_snapshot_request_i) begin
                update_live_reg <= 1'b0;
            end else if (snap_pulse) begin
                update_live_reg <= 1'b1;
            end
        end
    end

    // Nonzero set by each counted error, cleared by each snapshot, which wins over an error in the same cycle
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            nonzero_live_reg <= 1'b0;
        end else if (snap_pulse) begin
            nonzero_live_reg <= 1'b0;
        end else if (counted_err) begin
            nonzero_live_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sync_prev_reg    <= 1'b0;
            update_prev_reg  <= 1'b0;
            nonzero_prev_reg <= 1'b0;
        end else begin
            sync_prev_reg    <= sync_lost_live_i;
            update_prev_reg  <= update_live_reg;
            nonzero_prev_reg <= nonzero_live_reg;
        end
    end

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    // True when a write strobe targets the given offset
    function automatic logic wr_hit(
        input logic       wr,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        wr_hit = wr && (addr == target);
    endfunction

    logic wr_latched;
    logic wr_enable;

    assign wr_latched = wr_hit(reg_wr_i, reg_addr_i, bsc_pkg::OFS_LATCHED);
    assign wr_enable  = wr_hit(reg_wr_i, reg_addr_i, bsc_pkg::OFS_IRQ_ENABLE);

    // ------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------
    logic [3:0] sticky_reg;
    logic [3:0] sticky_set;
    logic [3:0] sticky_clr;
    logic [3:0] irq_en_reg;

    always_comb begin
        sticky_set = 4'h0;
        sticky_set[bsc_pkg::POS_UPDATE] =
            update_live_reg && !update_prev_reg;
        sticky_set[bsc_pkg::POS_ERROR] =
            counted_err;
        sticky_set[bsc_pkg::POS_COUNT] =
            nonzero_live_reg && !nonzero_prev_reg;
        sticky_set[bsc_pkg::POS_SYNC] =
            sync_lost_live_i != sync_prev_reg;
    end

    // Write one to clear; writes of zero leave a flag alone
    assign sticky_clr = wr_latched ? reg_wdata_i[3:0] : 4'h0;

    // One flag per bit; a set wins over a clear in the same cycle,
    // so an event that races the clear is never lost
    for (genvar i = 0; i < 4; i++) begin : g_sticky
        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                sticky_reg[i] <= bsc_pkg::RST_FLAGS[i];
            end else if (sticky_set[i]) begin
                sticky_reg[i] <= 1'b1;
            end else if (sticky_clr[i]) begin
                sticky_reg[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_en_reg <= bsc_pkg::RST_FLAGS;
        end else if (wr_enable) begin
            irq_en_reg <= reg_wdata_i[3:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    logic [3:0] gate_mask;
    logic [3:0] irq_src;

    // Update flag bypasses the port gate; the other three need it
    always_comb begin
        gate_mask = {4{port_status_irq_gate_i}};
        gate_mask[bsc_pkg::POS_UPDATE] = 1'b1;
    end

    for (genvar i = 0; i < 4; i++) begin : g_irq_src
        assign irq_src[i] = sticky_reg[i] && irq_en_reg[i] &&
                            gate_mask[i];
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |irq_src;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            update_done_live_o <= 1'b0;
        end else begin
            update_done_live_o <= update_live_reg;
        end
    end

    // ------------------------------------------------------------
    // Register read words
    // ------------------------------------------------------------
    logic [15:0] status_word;
    logic [15:0] latched_word;
    logic [15:0] enable_word;
    logic [15:0] err_low_word;
    logic [15:0] err_high_word;
    logic [15:0] bit_low_word;
    logic [15:0] bit_high_word;

    always_comb begin
        status_word = bsc_pkg::RST_REG16;
        status_word[bsc_pkg::POS_UPDATE] = update_live_reg;
        status_word[bsc_pkg::POS_COUNT]  = nonzero_live_reg;
        status_word[bsc_pkg::POS_SYNC]   = sync_lost_live_i;
    end

    // Unused upper bits of flag and enable words read zero
    always_comb begin
        latched_word      = bsc_pkg::RST_REG16;
        latched_word[3:0] = sticky_reg;
        enable_word       = bsc_pkg::RST_REG16;
        enable_word[3:0]  = irq_en_reg;
    end

    // Upper byte of the high error word always reads zero
    always_comb begin
        err_low_word       = error_tally_reg[15:0];
        err_high_word      = bsc_pkg::RST_REG16;
        err_high_word[7:0] = error_tally_reg[23:16];
    end

    // Both halves come from one snapshot, so read order is free
    always_comb begin
        bit_low_word  = received_bit_tally_reg[15:0];
        bit_high_word = received_bit_tally_reg[31:16];
    end

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    logic [15:0] rdata;

    always_comb begin
        rdata = bsc_pkg::RST_REG16;
        unique case (reg_addr_i)
            bsc_pkg::OFS_STATUS:     rdata = status_word;
            bsc_pkg::OFS_LATCHED:    rdata = latched_word;
            bsc_pkg::OFS_IRQ_ENABLE: rdata = enable_word;
            bsc_pkg::OFS_ERR_LOW:    rdata = err_low_word;
            bsc_pkg::OFS_ERR_HIGH:   rdata = err_high_word;
            bsc_pkg::OFS_BIT_LOW:    rdata = bit_low_word;
            bsc_pkg::OFS_BIT_HIGH:   rdata = bit_high_word;
            default:                 rdata = bsc_pkg::RST_REG16;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= bsc_pkg::RST_REG16;
        end else begin
            reg_rdata_o <= rdata;
        end
    end
endmodule

// ---- rtl/bsc_sat_counter.sv ----
`timescale 1ns/1ps
module bsc_sat_counter #(
    parameter int WIDTH = 24
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             inc_i,
    input  wire logic             hold_i,
    input  wire logic             restart_i,
    output logic [WIDTH-1:0]      count_o
);
    // ------------------------------------------------------------
    // Saturating accumulator; restart reloads with current event
    // ------------------------------------------------------------
    logic             step;
    logic [WIDTH-1:0] count_reg;

    assign step    = inc_i && !hold_i;
    assign count_o = count_reg;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            count_reg <= '0;
        end else if (restart_i) begin
            count_reg <= {{(WIDTH-1){1'b0}}, step};
        end else if (step && !(&count_reg)) begin
            count_reg <= count_reg + 1'b1;
        end
    end
endmodule

// ---- testbench/bsc_bert_status_props.sv ----
`timescale 1ns/1ps
module bsc_bert_status_props (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        counter_snapshot_request_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        irq_o,
    input wire logic        update_done_live_o
);
    // ---------------------------------------------
    // Enable writes seen since reset
    // ---------------------------------------------
    logic en_seen_reg;
    always_ff @(posedge clk_i) begin
        if (!resetn_i)
            en_seen_reg <= 1'b0;
        else if (reg_wr_i && reg_addr_i == 8'h70)
            en_seen_reg <= 1'b1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_unmapped_reads_zero: assert property (!($past(reg_addr_i) inside
        {8'h6C, 8'h6E, 8'h70, 8'h74, 8'h76, 8'h78, 8'h7A})
        |-> reg_rdata_o == 16'h0000) else $error("unmapped read");
    a_latched_upper_zero: assert property ($past(reg_addr_i) == 8'h6E
        |-> reg_rdata_o[15:4] == 12'h000) else $error("latched upper");
    a_enable_upper_zero: assert property ($past(reg_addr_i) == 8'h70
        |-> reg_rdata_o[15:4] == 12'h000) else $error("enable upper");
    a_err_high_byte: assert property ($past(reg_addr_i) == 8'h76
        |-> reg_rdata_o[15:8] == 8'h00) else $error("error high byte");
    a_reset_clears_out: assert property ($rose(resetn_i)
        |-> !irq_o && !update_done_live_o && reg_rdata_o == 16'h0000)
        else $error("outputs after reset");
    a_update_done_rise: assert property (
        $rose(counter_snapshot_request_i) |-> ##[1:3] update_done_live_o)
        else $error("update late");
    a_update_release: assert property (!counter_snapshot_request_i
        ##1 !counter_snapshot_request_i |=> !update_done_live_o)
        else $error("update not released");
    a_irq_needs_enable: assert property (!en_seen_reg |-> !irq_o)
        else $error("irq without enable");
endmodule
bind bsc_bert_status bsc_bert_status_props u_props (
    .clk_i                      (clk_i),
    .resetn_i                   (resetn_i),
    .counter_snapshot_request_i (counter_snapshot_request_i),
    .reg_wr_i                   (reg_wr_i),
    .reg_addr_i                 (reg_addr_i),
    .reg_rdata_o                (reg_rdata_o),
    .irq_o                      (irq_o),
    .update_done_live_o         (update_done_live_o)
);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 0, resetn_i = 0, rx_bit_valid_i = 0, rx_bit_error_i = 0;
    logic sync_lost_live_i = 0, counter_snapshot_request_i = 0;
    logic port_status_irq_gate_i = 0, reg_wr_i = 0, irq_o;
    logic update_done_live_o;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
    int num_errors = 0, checked = 0;
    always #10 clk_i = ~clk_i;
    bsc_bert_status uut (.*);
    // ---------------------------------------------
    // Access and compare tasks
    // ---------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %0t read %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk_i);
        reg_addr_i = a;
        @(negedge clk_i);
        chk(reg_rdata_o, e);
    endtask
    task automatic bits(input int n, input int e);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            rx_bit_valid_i = 1'b1;
            rx_bit_error_i = (i < e);
        end
        @(negedge clk_i);
        rx_bit_valid_i = 1'b0;
        rx_bit_error_i = 1'b0;
    endtask
    task automatic snap();
        @(negedge clk_i);
        counter_snapshot_request_i = 1'b1;
        repeat (5) @(negedge clk_i);
        chk1(update_done_live_o, 1'b1);
        counter_snapshot_request_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk1(update_done_live_o, 1'b0);
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        wrap_up();
    end
    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    initial begin
        repeat (4) @(negedge clk_i);
        resetn_i = 1'b1;
        for (int a = 8'h6C; a <= 8'h7E; a += 2) begin
            rd(a[7:0], 16'h0000);
        end
        wr(8'h70, 16'hFFFF);
        rd(8'h70, 16'h000F);
        wr(8'h70, 16'h0000);
        wr(8'h74, 16'hFFFF);
        bits(10, 3);
        snap();
        rd(8'h74, 16'h0003);
        rd(8'h76, 16'h0000);
        rd(8'h78, 16'h000A);
        rd(8'h7A, 16'h0000);
        rd(8'h6E, 16'h000E);
        chk1(irq_o, 1'b0);
        wr(8'h70, 16'h0008);
        chk1(irq_o, 1'b1);
        wr(8'h70, 16'h0004);
        chk1(irq_o, 1'b0);
        port_status_irq_gate_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk1(irq_o, 1'b1);
        wr(8'h6E, 16'h000F);
        rd(8'h6E, 16'h0000);
        chk1(irq_o, 1'b0);
        sync_lost_live_i = 1'b1;
        rd(8'h6E, 16'h0001);
        rd(8'h6C, 16'h0001);
        bits(5, 2);
        wr(8'h6E, 16'h000F);
        sync_lost_live_i = 1'b0;
        rd(8'h6E, 16'h0001);
        bits(4, 1);
        rd(8'h6C, 16'h0002);
        snap();
        rd(8'h6C, 16'h0000);
        rd(8'h74, 16'h0001);
        rd(8'h78, 16'h0004);
        rd(8'h6E, 16'h000F);
        wr(8'h70, 16'h0003);
        chk1(irq_o, 1'b1);
        port_status_irq_gate_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk1(irq_o, 1'b0);
        wrap_up();
    end
endmodule
